// ===== hw/rst_wdog_pkg.sv
// Constants, types and encodings for the reset and watchdog block.
// Assumes a single 200 MHz clock and an APB master on the register side.
// Function
// - Hold reset 4064 cycles after power-on
// - Stay in reset while pin low
// - Drive reset pin low four cycles
// - Sample pin two cycles later, classify
// - Power-on and pin share one vector
// - Vectors FFFE/FFFC/FFFA, special modes BFxx
// - Reset aborts instruction, loads vector
// - Disable bit acts after next reset
// - Disable zero enables, one disables watchdog
// - Special modes start with watchdog resets inhibited
// - Count E over 2^15 times rate
// - Reset clears rate field to zero
// - Rate written once within 64 cycles, any time in special modes
// - 0x55 then 0xAA restarts watchdog
// - Expiry without service forces reset
package rst_wdog_pkg;
    // ===========================================================
    // Register map
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] SVC_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS = 12'h008;
    localparam int DIS_BIT = 0;
    localparam int INH_BIT = 1;
    localparam int CME_BIT = 2;
    localparam int RATE_LSB = 4;
    localparam int VEC_LSB = 16;
    localparam logic [7:0] ARM_VAL = 8'h55;
    localparam logic [7:0] CLR_VAL = 8'hAA;
    // ===========================================================
    // Timing, in E clock cycles
    localparam int POR_CYC = 4064;
    localparam int DRIVE_CYC = 4;
    localparam int SAMPLE_CYC = 2;
    localparam int RATE_WIN = 64;
    localparam int CNT_W = 12;
    // ===========================================================
    // Vectors
    localparam logic [7:0] VEC_NORM_HI = 8'hFF;
    localparam logic [7:0] VEC_SPEC_HI = 8'hBF;
    localparam logic [7:0] VEC_POR_LO = 8'hFE;
    localparam logic [7:0] VEC_CM_LO = 8'hFC;
    localparam logic [7:0] VEC_WD_LO = 8'hFA;
    // ===========================================================
    // Types
    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_PINW = 3'b001,
        ST_DRIVE = 3'b010,
        ST_SAMP = 3'b011,
        ST_RUN = 3'b100
    } rst_state_e;
    typedef enum logic [1:0] {
        C_POR = 2'b00,
        C_EXT = 2'b01,
        C_CM = 2'b10,
        C_WD = 2'b11
    } cause_e;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;
    typedef struct packed {
        logic drv;
        logic oe;
    } pin_drive_s;
endpackage : rst_wdog_pkg

// ===== hw/rst_wdog.sv
// Reset sequencer, reset pin handling and software watchdog.
// Assumes the reset pin and clock-fail flag are asynchronous inputs.
`timescale 1ns/1ps
module rst_wdog #(
    parameter int E_DIV = 50,
    parameter int PRE_BITS = 15
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire rst_wdog_pkg::apb_req_s apb_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    input wire logic rst_pin_i,
    output rst_wdog_pkg::pin_drive_s rst_pin_o,
    input wire logic clock_fail_i,
    input wire logic special_mode_i,
    output logic cpu_reset_o,
    output logic vector_load_o,
    output logic [15:0] vector_o
);
    import rst_wdog_pkg::*;

    // ===========================================================
    // Helpers
    function automatic logic [5:0] scale_limit(input logic [1:0] r);
        case (r)
            2'b00: scale_limit = 6'h00;
            2'b01: scale_limit = 6'h03;
            2'b10: scale_limit = 6'h0F;
            default: scale_limit = 6'h3F;
        endcase
    endfunction : scale_limit

    function automatic logic [15:0] vec_of(input cause_e c, input logic sp);
        logic [7:0] lo;
        lo = (c == C_WD) ? VEC_WD_LO : (c == C_CM) ? VEC_CM_LO : VEC_POR_LO;
        vec_of = {sp ? VEC_SPEC_HI : VEC_NORM_HI, lo};
    endfunction : vec_of

    // ===========================================================
    // E clock enable
    logic [7:0] div_q;
    logic e_tick_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= 8'h00;
            e_tick_q <= 1'b0;
        end else if (div_q == 8'(E_DIV - 1)) begin
            div_q <= 8'h00;
            e_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 8'h01;
            e_tick_q <= 1'b0;
        end
    end

    // ===========================================================
    // Input synchronisers
    logic [2:0] pin_s_q;
    logic [2:0] cf_s_q;
    logic pin_lvl_q;
    logic cf_lvl_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s_q <= 3'b111;
            cf_s_q <= 3'b000;
            pin_lvl_q <= 1'b1;
            cf_lvl_q <= 1'b0;
        end else begin
            pin_s_q <= {pin_s_q[1:0], rst_pin_i};
            cf_s_q <= {cf_s_q[1:0], clock_fail_i};
            if (pin_s_q[1] == pin_s_q[2]) begin
                pin_lvl_q <= pin_s_q[2];
            end
            if (cf_s_q[1] == cf_s_q[2]) begin
                cf_lvl_q <= cf_s_q[2];
            end
        end
    end

    // ===========================================================
    // Sequencer
    rst_state_e state_q, state_d;
    cause_e cause_q, cause_d, pend_q;
    logic [CNT_W-1:0] cnt_q;
    logic special_q;
    logic dis_q, inh_q, cme_q, wd_en_q, arm_q, rate_wr_q;
    logic [1:0] rate_q;
    logic [PRE_BITS-1:0] pre_q;
    logic [5:0] sc_q;
    logic [6:0] bus_cnt_q;
    logic sys_rst;
    logic wd_exp, wd_fire, cm_fire, cnt_end;
    logic wr_acc, svc_wr, svc_restart;

    assign sys_rst = (state_q != ST_RUN);
    assign wd_exp = e_tick_q && (&pre_q) && (sc_q == scale_limit(rate_q));
    assign wd_fire = wd_exp && wd_en_q && !inh_q;
    assign cm_fire = cme_q && cf_lvl_q;

    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        cnt_end = 1'b0;
        case (state_q)
            ST_POR: begin
                cnt_end = e_tick_q && (cnt_q == CNT_W'(POR_CYC - 1));
                if (cnt_end) begin
                    state_d = ST_PINW;
                end
            end
            ST_PINW: begin
                if (pin_lvl_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_DRIVE: begin
                cnt_end = e_tick_q && (cnt_q == CNT_W'(DRIVE_CYC - 1));
                if (cnt_end) begin
                    state_d = ST_SAMP;
                end
            end
            ST_SAMP: begin
                // classify on pin level
                // E_DIV below 3 lets the pin synchroniser lag this sample
                cnt_end = e_tick_q && (cnt_q == CNT_W'(SAMPLE_CYC - 1));
                if (cnt_end) begin
                    if (!pin_lvl_q) begin
                        cause_d = C_EXT;
                        state_d = ST_PINW;
                    end else begin
                        cause_d = pend_q;
                        state_d = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (wd_fire || cm_fire || !pin_lvl_q) begin
                    state_d = ST_DRIVE;
                end
            end
            default: state_d = ST_POR;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_POR;
            cause_q <= C_POR;
            pend_q <= C_EXT;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cause_q <= cause_d;
            if (state_d != state_q) begin
                cnt_q <= '0;
            end else if (e_tick_q) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
            if (state_q == ST_RUN && state_d == ST_DRIVE) begin
                pend_q <= wd_fire ? C_WD : (cm_fire ? C_CM : C_EXT);
            end
        end
    end

    // ===========================================================
    // Outputs toward pin and CPU
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_pin_o <= '0;
            cpu_reset_o <= 1'b1;
            vector_load_o <= 1'b0;
            vector_o <= 16'h0000;
        end else begin
            rst_pin_o.drv <= 1'b0;
            rst_pin_o.oe <= (state_d == ST_DRIVE);
            cpu_reset_o <= (state_d != ST_RUN);
            vector_load_o <= sys_rst && (state_d == ST_RUN);
            vector_o <= vec_of(cause_d, special_q);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            special_q <= 1'b0;
        end else if (state_q == ST_POR) begin
            special_q <= special_mode_i;
        end
    end

    // ===========================================================
    // APB slave
    assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite && pready_o;
    assign svc_wr = wr_acc && (apb_i.paddr == SVC_OFS);
    assign svc_restart = svc_wr && arm_q && (apb_i.pwdata[7:0] == CLR_VAL);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= apb_i.psel && !apb_i.penable;
            pslverr_o <= apb_i.psel && !apb_i.penable && (apb_i.paddr != CTRL_OFS)
                && (apb_i.paddr != SVC_OFS) && (apb_i.paddr != STAT_OFS);
            prdata_o <= 32'h0000_0000;
            if (apb_i.paddr == CTRL_OFS) begin
                prdata_o[DIS_BIT] <= dis_q;
                prdata_o[INH_BIT] <= inh_q;
                prdata_o[CME_BIT] <= cme_q;
                prdata_o[RATE_LSB +: 2] <= rate_q;
            end else if (apb_i.paddr == STAT_OFS) begin
                prdata_o[1:0] <= cause_q;
                prdata_o[2] <= wd_en_q;
                prdata_o[3] <= arm_q;
                prdata_o[4] <= special_q;
                prdata_o[VEC_LSB +: 16] <= vector_o;
            end
        end
    end

    // ===========================================================
    // Configuration; disable bit survives internal resets
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dis_q <= 1'b0;
        end else if (wr_acc && apb_i.paddr == CTRL_OFS) begin
            dis_q <= apb_i.pwdata[DIS_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wd_en_q <= 1'b0;
            inh_q <= 1'b0;
            cme_q <= 1'b0;
            rate_q <= 2'b00;
            rate_wr_q <= 1'b0;
            bus_cnt_q <= 7'h00;
        end else if (sys_rst) begin
            wd_en_q <= !dis_q;
            inh_q <= special_q;
            cme_q <= 1'b0;
            rate_q <= 2'b00;
            rate_wr_q <= 1'b0;
            bus_cnt_q <= 7'h00;
        end else begin
            if (e_tick_q && bus_cnt_q != 7'(RATE_WIN)) begin
                bus_cnt_q <= bus_cnt_q + 7'h01;
            end
            if (wr_acc && apb_i.paddr == CTRL_OFS) begin
                inh_q <= inh_q & apb_i.pwdata[INH_BIT];
                cme_q <= apb_i.pwdata[CME_BIT];
                if (special_q || (!rate_wr_q && bus_cnt_q < 7'(RATE_WIN))) begin
                    rate_q <= apb_i.pwdata[RATE_LSB +: 2];
                    rate_wr_q <= 1'b1;
                end
            end
        end
    end

    // ===========================================================
    // Watchdog counter and arm flag
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            arm_q <= 1'b0;
            pre_q <= '0;
            sc_q <= 6'h00;
        end else if (sys_rst) begin
            arm_q <= 1'b0;
            pre_q <= '0;
            sc_q <= 6'h00;
        end else begin
            if (svc_wr && apb_i.pwdata[7:0] == ARM_VAL) begin
                arm_q <= 1'b1;
            end else if (svc_restart) begin
                arm_q <= 1'b0;
            end
            if (svc_restart) begin
                pre_q <= '0;
                sc_q <= 6'h00;
            end else if (e_tick_q) begin
                pre_q <= pre_q + PRE_BITS'(1);
                if (&pre_q) begin
                    sc_q <= wd_exp ? 6'h00 : sc_q + 6'h01;
                end
            end
        end
    end

    // ===========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_drive_len: assert property (
        $rose(rst_pin_o.oe) |-> rst_pin_o.oe [*4]) else $error("pin drive too short");
    chk_pin_hold: assert property (
        state_q == ST_PINW && !pin_lvl_q |=> cpu_reset_o) else $error("left reset with pin low");
    chk_ext_class: assert property (
        state_q == ST_SAMP && cnt_end && !pin_lvl_q |=> cause_q == C_EXT) else $error("bad class");
    chk_vec_wd: assert property (
        vector_load_o && cause_q == C_WD |-> vector_o[7:0] == VEC_WD_LO) else $error("bad wd vector");
    chk_vec_load: assert property (
        $fell(cpu_reset_o) |-> vector_load_o) else $error("no vector load");
    chk_wd_fire: assert property (
        state_q == ST_RUN && wd_fire |=> state_q == ST_DRIVE) else $error("expiry ignored");
    chk_wd_off: assert property (
        !wd_en_q && state_q == ST_RUN && pin_lvl_q && !cm_fire |=> state_q == ST_RUN)
        else $error("disabled watchdog reset");
    chk_rate_rst: assert property (
        $rose(sys_rst) |=> rate_q == 2'b00) else $error("rate not cleared");
    chk_unarmed: assert property (
        svc_wr && !arm_q && !sys_rst && !e_tick_q |=> sc_q == $past(sc_q) && pre_q == $past(pre_q))
        else $error("unarmed restart");
    chk_por_time: assert property (
        state_q == ST_POR |-> cnt_q < CNT_W'(POR_CYC)) else $error("por overrun");
endmodule : rst_wdog

// ===== test/ext_reset_circuit.sv
// External reset circuit on the open-drain reset pin.
// Assumes the device pulls the pin low while its enable is high.
`timescale 1ns/1ps
module ext_reset_circuit (
    input wire logic dev_pull_i,
    input wire logic dev_drv_i,
    input wire logic hold_low_i,
    output logic pin_o
);
    // ==========
    // Pin level
    // Pull-up wins unless the device drives a zero or the circuit holds low
    assign pin_o = !((dev_pull_i && !dev_drv_i) || hold_low_i);
endmodule : ext_reset_circuit

// ===== test/tb_rst_wdog.sv
// Testbench for the reset sequencer and watchdog.
// Assumes short prescale parameters and APB access through the request struct.
`timescale 1ns/1ps
module tb_rst_wdog;
    import rst_wdog_pkg::*;
    // Below 3 the pin synchroniser cannot settle before the sample point
    localparam int E_DIV = 4;
    logic clk_i, arst_n, pin, hold, cfail, special, pready, perr, cpu_rst, vload;
    logic [31:0] prdata;
    logic [15:0] vec;
    apb_req_s req;
    pin_drive_s drv;
    int mismatches, total_checks, cycles, oe_cyc;

    rst_wdog #(.E_DIV(E_DIV), .PRE_BITS(6)) dut (.clk_i(clk_i), .arst_n_i(arst_n), .apb_i(req),
        .pready_o(pready), .pslverr_o(perr), .prdata_o(prdata), .rst_pin_i(pin), .rst_pin_o(drv),
        .clock_fail_i(cfail), .special_mode_i(special), .cpu_reset_o(cpu_rst), .vector_load_o(vload),
        .vector_o(vec));
    ext_reset_circuit far (.dev_pull_i(drv.oe), .dev_drv_i(drv.drv), .hold_low_i(hold), .pin_o(pin));

    initial begin
        clk_i = 0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (drv.oe === 1'b1) oe_cyc++;
        if (cycles == 60000) begin
            mismatches++;
            close_out();
        end
    end

    // ==========
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic er);
        @(posedge clk_i);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
        @(posedge clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        req <= '0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        check(nm, rd & m, e);
    endtask : rdc

    task automatic wait_exit(input logic [15:0] v, input logic [1:0] c, input bit pulled);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (vload !== 1'b1 && n < 5000);
        check("vector", {16'h0, vec}, {16'h0, v});
        check("oe_len", {31'h0, pulled ? (oe_cyc >= 3 * E_DIV && oe_cyc <= 4 * E_DIV + 1) : (oe_cyc == 0)}, 1);
        rdc("cause", STAT_OFS, 32'h0000_0003, {30'h0, c});
        rdc("rate", CTRL_OFS, 32'h0000_0030, 32'h0);
        oe_cyc = 0;
    endtask : wait_exit

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // ==========
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic er;
        int n;
        req = '0;
        hold = 1;
        cfail = 0;
        special = 0;
        arst_n = 0;
        repeat (20) @(posedge clk_i);
        arst_n <= 1;
        repeat (4000 * E_DIV) @(posedge clk_i);
        check("por_hold", {31'h0, cpu_rst}, 1);
        repeat (100 * E_DIV) @(posedge clk_i);
        check("pin_hold", {31'h0, cpu_rst}, 1);
        oe_cyc = 0;
        hold <= 0;
        wait_exit(16'hFFFE, 2'd0, 0);
        wr(CTRL_OFS, 32'h0000_0010);
        wr(CTRL_OFS, 32'h0000_0020);
        rdc("rate_once", CTRL_OFS, 32'h0000_0030, 32'h0000_0010);
        apb(1'b0, 12'h0FC, 32'h0, rd, er);
        check("slverr", {31'h0, er}, 1);
        wr(SVC_OFS, 32'h0000_00AA);
        rdc("armed", STAT_OFS, 32'h0000_0008, 32'h0);
        wr(SVC_OFS, 32'h0000_0055);
        wr(SVC_OFS, 32'h0000_0012);
        rdc("armed", STAT_OFS, 32'h0000_0008, 32'h0000_0008);
        wr(SVC_OFS, 32'h0000_00AA);
        rdc("armed", STAT_OFS, 32'h0000_0008, 32'h0);
        // Serviced well past one timeout of 256 ticks
        repeat (12) begin
            repeat (100) @(posedge clk_i);
            wr(SVC_OFS, 32'h0000_0055);
            wr(SVC_OFS, 32'h0000_00AA);
        end
        check("serviced", {31'h0, cpu_rst}, 0);
        wait_exit(16'hFFFA, 2'd3, 1);
        hold <= 1;
        repeat (40) @(posedge clk_i);
        hold <= 0;
        wait_exit(16'hFFFE, 2'd1, 1);
        wr(CTRL_OFS, 32'h0000_0005);
        rdc("wd_active", STAT_OFS, 32'h0000_0004, 32'h0000_0004);
        cfail <= 1;
        repeat (10) @(posedge clk_i);
        cfail <= 0;
        wait_exit(16'hFFFC, 2'd2, 1);
        rdc("wd_active", STAT_OFS, 32'h0000_0004, 32'h0);
        repeat (700) @(posedge clk_i);
        check("no_wd", {31'h0, cpu_rst}, 0);
        // Second power-on in mid-run, with the special-mode strap set
        special <= 1;
        arst_n <= 0;
        repeat (20) @(posedge clk_i);
        arst_n <= 1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (vload !== 1'b1);
        check("por_len", {31'h0, n >= POR_CYC * E_DIV && n <= (POR_CYC + 2) * E_DIV}, 1);
        check("vec_special", {16'h0, vec}, 32'h0000_BFFE);
        rdc("special", STAT_OFS, 32'h0000_0014, 32'h0000_0014);
        rdc("inhibit", CTRL_OFS, 32'h0000_0002, 32'h0000_0002);
        repeat (700) @(posedge clk_i);
        check("inhibited", {31'h0, cpu_rst}, 0);
        oe_cyc = 0;
        wr(CTRL_OFS, 32'h0000_0000);
        wait_exit(16'hBFFA, 2'd3, 1);
        close_out();
    end
endmodule : tb_rst_wdog
